//--- design/tws_slave.sv
`timescale 1ns/1ps
module tws_slave (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // serial bus pins
    input  wire logic        serial_clock,
    input  wire logic        serial_bus_line_in,
    output logic             serial_bus_line_out,
    output logic             serial_bus_line_oe,
    // strap
    input  wire logic        address_select_pin,
    // register side
    output logic [15:0]      reg_addr,
    output logic [7:0]       reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [7:0]  reg_rdata,
    // status
    output logic             bus_busy
);
    logic                scl_s;
    logic                sda_s;
    logic                scl_d_r;
    logic                sda_d_r;
    tws_pkg::tws_state_t state_r;
    tws_pkg::tws_state_t state_nxt;
    logic [15:0]         ptr_r;
    logic                ack_r;
    logic                rd_pend_r;
    logic                wr_r;
    logic [7:0]          wdata_r;
    logic                strap_r;
    logic                strap_taken_r;
    logic                seen_rise_r;
    logic [7:0]          shreg;
    logic [3:0]          bitcnt;

    tws_sync u_sync_scl (
        .clk   (mclk),
        .reset (reset),
        .din   (serial_clock),
        .dout  (scl_s)
    );

    tws_sync u_sync_sda (
        .clk   (mclk),
        .reset (reset),
        .din   (serial_bus_line_in),
        .dout  (sda_s)
    );

    // edges of the filtered lines
    wire scl_rise   = scl_s & ~scl_d_r;
    wire scl_fall   = ~scl_s & scl_d_r;
    wire start_seen = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_seen  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    wire in_data    = (bitcnt <= tws_pkg::BIT_LAST);
    wire in_ack     = (bitcnt == tws_pkg::BIT_ACK);
    // byte complete: the eighth bit was sampled on this rise
    wire byte_done  = scl_rise & (bitcnt == tws_pkg::BIT_LAST);
    wire [7:0] byte_in = {shreg[6:0], sda_s};

    wire [6:0] own_addr = strap_r ? tws_pkg::ADDR_SEL_HIGH
                                  : tws_pkg::ADDR_SEL_LOW;
    wire addr_match = (byte_in[7:1] == own_addr);
    wire is_read    = byte_in[0];

    // host acknowledge sampled on the rising clock in the ack slot
    wire host_ack   = scl_rise & in_ack & ~sda_s;
    wire host_nack  = scl_rise & in_ack & sda_s;

    wire rd_slot    = (state_r == tws_pkg::TWS_RDATA);
    // reload read byte at the fall that opens the address ack slot, then at each fall that ends a read ack slot the host acknowledged
    wire load_rd    = rd_pend_r & ~scl_s;
    // the byte being loaded is not in the shifter yet on its own load cycle
    wire rd_bit     = load_rd ? reg_rdata[7] : shreg[7];
    // a fall ends a bit slot only after a rise; the fall that follows a start is no bit
    wire bit_end    = scl_fall & seen_rise_r & (state_r != tws_pkg::TWS_IDLE);

    tws_shifter u_shift (
        .clk        (mclk),
        .reset      (reset),
        .clear      (start_seen | stop_seen),
        .load       (load_rd),
        .load_val   (reg_rdata),
        .sample     (scl_rise & in_data),
        .sample_bit (sda_s),
        .advance    (bit_end),
        .shreg      (shreg),
        .bitcnt     (bitcnt)
    );

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            tws_pkg::TWS_IDLE:   state_nxt = state_r;
            tws_pkg::TWS_DEVADR: begin
                if (byte_done) begin
                    if (!addr_match) begin
                        state_nxt = tws_pkg::TWS_IGNORE;
                    end else if (is_read) begin
                        state_nxt = tws_pkg::TWS_RDATA;
                    end else begin
                        state_nxt = tws_pkg::TWS_ADR_HI;
                    end
                end
            end
            tws_pkg::TWS_ADR_HI: if (byte_done) state_nxt = tws_pkg::TWS_ADR_LO;
            tws_pkg::TWS_ADR_LO: if (byte_done) state_nxt = tws_pkg::TWS_WDATA;
            tws_pkg::TWS_WDATA:  state_nxt = state_r;
            tws_pkg::TWS_RDATA:  if (host_nack) state_nxt = tws_pkg::TWS_IGNORE;
            tws_pkg::TWS_IGNORE: state_nxt = state_r;
            default:             state_nxt = tws_pkg::TWS_IDLE;
        endcase
        if (start_seen) begin
            state_nxt = tws_pkg::TWS_DEVADR;
        end else if (stop_seen) begin
            state_nxt = tws_pkg::TWS_IDLE;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            state_r <= tws_pkg::TWS_IDLE;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            seen_rise_r <= 1'b0;
        end else if (start_seen | stop_seen) begin
            seen_rise_r <= 1'b0;
        end else if (scl_rise) begin
            seen_rise_r <= 1'b1;
        end else if (scl_fall) begin
            seen_rise_r <= 1'b0;
        end
    end

    // strap caught once after reset release
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            strap_r       <= 1'b0;
            strap_taken_r <= 1'b0;
        end else if (!strap_taken_r) begin
            strap_r       <= address_select_pin;
            strap_taken_r <= 1'b1;
        end
    end

    // acknowledge drive: set when a byte that needs it completes, held through the slot
    wire need_ack = byte_done & ((state_r == tws_pkg::TWS_DEVADR & addr_match)
                                 | state_r == tws_pkg::TWS_ADR_HI
                                 | state_r == tws_pkg::TWS_ADR_LO
                                 | state_r == tws_pkg::TWS_WDATA);

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ack_r <= 1'b0;
        end else if (start_seen | stop_seen) begin
            ack_r <= 1'b0;
        end else if (need_ack) begin
            ack_r <= 1'b1;
        end else if (scl_fall & in_ack) begin
            ack_r <= 1'b0;
        end
    end

    // pointer, write strobe and read request
    wire wr_byte   = byte_done & (state_r == tws_pkg::TWS_WDATA);
    wire rd_enter  = byte_done & (state_r == tws_pkg::TWS_DEVADR) & addr_match & is_read;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ptr_r     <= tws_pkg::PTR_RESET;
            wr_r      <= 1'b0;
            wdata_r   <= 8'h00;
            rd_pend_r <= 1'b0;
        end else begin
            wr_r <= wr_byte;
            if (byte_done & state_r == tws_pkg::TWS_ADR_HI) begin
                ptr_r[15:8] <= byte_in;
            end else if (byte_done & state_r == tws_pkg::TWS_ADR_LO) begin
                ptr_r[7:0] <= byte_in;
            end else if (wr_r) begin
                ptr_r <= ptr_r + 16'h0001;
            end else if (rd_slot & scl_rise & (bitcnt == tws_pkg::BIT_LAST)) begin
                ptr_r <= ptr_r + 16'h0001;
            end
            if (wr_byte) begin
                wdata_r <= byte_in;
            end
            if (start_seen | stop_seen | host_nack) begin
                rd_pend_r <= 1'b0;
            end else if (rd_enter | (host_ack & rd_slot)) begin
                rd_pend_r <= 1'b1;
            end else if (load_rd) begin
                rd_pend_r <= 1'b0;
            end
        end
    end

    // the sensor drives low only: acknowledge or a zero read bit
    // slot opened by this fall; moving the line at the fall itself leaves a clock of margin
    // before the host raises the clock again, despite the synchroniser lag
    wire [3:0] slot_nxt   = in_ack ? 4'h0 : bitcnt + 4'h1;
    wire       drive_ack  = ack_r & (slot_nxt == tws_pkg::BIT_ACK);
    wire       drive_data = rd_slot & (slot_nxt <= tws_pkg::BIT_LAST) & ~rd_bit;

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            serial_bus_line_oe <= 1'b0;
        end else if (start_seen | stop_seen) begin
            serial_bus_line_oe <= 1'b0;
        end else if (bit_end) begin
            serial_bus_line_oe <= drive_ack | drive_data;
        end
    end

    // busy from start until stop
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            bus_busy <= 1'b0;
        end else begin
            bus_busy <= (state_nxt != tws_pkg::TWS_IDLE);
        end
    end

    assign serial_bus_line_out = 1'b0;
    assign reg_addr            = ptr_r;
    assign reg_wdata           = wdata_r;
    assign reg_wr              = wr_r;
    assign reg_rd              = load_rd;
endmodule

//--- design/tws_pkg.sv
package tws_pkg;
    localparam logic [6:0] ADDR_SEL_LOW  = 7'h48;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h5D;
    localparam int         BYTE_BITS     = 8;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    localparam logic [15:0] PTR_RESET    = 16'h0000;
    localparam int         SYNC_STAGES   = 3;

    typedef enum logic [6:0] {
        TWS_IDLE    = 7'h01,
        TWS_DEVADR  = 7'h02,
        TWS_ADR_HI  = 7'h04,
        TWS_ADR_LO  = 7'h08,
        TWS_WDATA   = 7'h10,
        TWS_RDATA   = 7'h20,
        TWS_IGNORE  = 7'h40
    } tws_state_t;
endpackage

//--- design/tws_sync.sv
`timescale 1ns/1ps
// three-stage synchroniser; a change counts once stages two and three agree
module tws_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // pin and filtered level
    input  wire logic din,
    output logic      dout
);
    logic [2:0] sh_r;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sh_r <= 3'h7;
            dout <= 1'b1;
        end else begin
            sh_r <= {sh_r[1:0], din};
            if (sh_r[1] == sh_r[2]) begin
                dout <= sh_r[2];
            end
        end
    end
endmodule

//--- design/tws_shifter.sv
`timescale 1ns/1ps
// bit counter and shift register for one byte plus acknowledge slot
module tws_shifter (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // control
    input  wire logic       clear,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    input  wire logic       sample,
    input  wire logic       sample_bit,
    input  wire logic       advance,
    // state
    output logic [7:0]      shreg,
    output logic [3:0]      bitcnt
);
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shreg  <= 8'h00;
            bitcnt <= 4'h0;
        end else if (clear) begin
            bitcnt <= 4'h0;
        end else begin
            if (load) begin
                shreg <= load_val;
            end else if (sample) begin
                shreg <= {shreg[6:0], sample_bit};
            end
            if (advance) begin
                bitcnt <= (bitcnt == tws_pkg::BIT_ACK) ? 4'h0 : bitcnt + 4'h1;
            end
        end
    end
endmodule

//--- verif/tws_host_model.sv
`timescale 1ns/1ps
// host master; a released pin floats high through the pull-up
module tws_host_model (
    // clock
    input  wire logic clk,
    // serial bus pins
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic start();
        sda_drv <= 1'b1;
        tick(3);
        scl <= 1'b1;
        tick(3);
        sda_drv <= 1'b0;
        tick(3);
        scl <= 1'b0;
        tick(3);
    endtask
    task automatic stop();
        sda_drv <= 1'b0;
        tick(3);
        scl <= 1'b1;
        tick(3);
        sda_drv <= 1'b1;
        tick(6);
    endtask
    // long low phase leaves room for the slave's synchroniser lag
    task automatic bit_io(input logic b, output logic r);
        sda_drv <= b;
        tick(3);
        scl <= 1'b1;
        tick(2);
        r = sda_line;
        scl <= 1'b0;
        tick(3);
    endtask
    task automatic wr_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(v[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask
    task automatic rd_byte(input logic nack, output logic [7:0] v, output logic lv);
        for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
        bit_io(nack, lv);
    endtask
endmodule

//--- verif/tws_slave_properties.sv
`timescale 1ns/1ps
module tws_slave_chk (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset,
    // serial bus pins
    input  wire logic        serial_clock,
    input  wire logic        serial_bus_line_in,
    input  wire logic        serial_bus_line_out,
    input  wire logic        serial_bus_line_oe,
    // register side and status
    input  wire logic [15:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        bus_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    a_drive_low: assert property (serial_bus_line_oe |-> !serial_bus_line_out)
        else $error("pin driven high");
    a_wr_pulse: assert property (reg_wr |=> !reg_wr)
        else $error("write strobe too long");
    a_ptr_step: assert property (reg_wr |=> reg_addr == $past(reg_addr) + 16'h0001)
        else $error("pointer not stepped");
    a_start_busy: assert property (serial_clock && $fell(serial_bus_line_in) |-> ##[1:8] bus_busy)
        else $error("start missed");
    a_stop_idle: assert property (serial_clock && $rose(serial_bus_line_in) |-> ##[1:8] !bus_busy)
        else $error("stop missed");
    // the slave may only move the line while the clock is low
    a_steady_high: assert property (serial_clock && $past(serial_clock) |-> $stable(serial_bus_line_oe))
        else $error("line moved in high clock");
    a_idle_quiet: assert property (!bus_busy |-> !serial_bus_line_oe && !reg_wr)
        else $error("activity while idle");
    a_rd_busy: assert property (reg_rd |-> bus_busy)
        else $error("read outside transfer");
endmodule
bind tws_slave tws_slave_chk chk_u (.mclk(mclk), .reset(reset), .serial_clock(serial_clock),
    .serial_bus_line_in(serial_bus_line_in), .serial_bus_line_out(serial_bus_line_out),
    .serial_bus_line_oe(serial_bus_line_oe), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .bus_busy(bus_busy));

//--- verif/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin miscompares++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module testbench;
    logic        mclk;
    logic        reset;
    logic        pin_sel;
    logic        scl;
    logic        sda_drv;
    logic        oe;
    logic        busy;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  mem [0:255];
    wire  logic  sda = sda_drv & ~oe;
    int          miscompares;
    int          comparisons;
    tws_slave dut_u (.mclk(mclk), .reset(reset), .serial_clock(scl), .serial_bus_line_in(sda),
        .serial_bus_line_out(), .serial_bus_line_oe(oe), .address_select_pin(pin_sel),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(),
        .reg_rdata(mem[addr[7:0]]), .bus_busy(busy));
    tws_host_model host_u (.clk(mclk), .sda_line(sda), .scl(scl), .sda_drv(sda_drv));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(posedge mclk) if (wr) mem[addr[7:0]] <= wdata;
    task automatic finish_test();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 30; i++) begin
            if (busy === 1'b0) return;
            @(posedge mclk);
        end
        miscompares++;
        finish_test();
    endtask
    task automatic do_reset(input logic sel);
        reset <= 1'b1;
        pin_sel <= sel;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        repeat (6) @(posedge mclk);
        `CHK(addr, tws_pkg::PTR_RESET)
        `CHK(busy, 1'b0)
    endtask
    task automatic send(input logic [7:0] v, input logic exp);
        logic a;
        host_u.wr_byte(v, a);
        `CHK(a, exp)
    endtask
    task automatic rd(input logic nack, input logic [7:0] exp);
        logic [7:0] v;
        logic       lv;
        host_u.rd_byte(nack, v, lv);
        `CHK(v, exp)
        `CHK(lv, nack)
    endtask
    task automatic t_write();
        host_u.start();
        send(8'h90, 1'b1);
        send(8'h12, 1'b1);
        send(8'h34, 1'b1);
        send(8'hA5, 1'b1);
        send(8'h5A, 1'b1);
        send(8'hC3, 1'b1);
        host_u.stop();
        wait_idle();
        `CHK(mem[8'h34], 8'hA5)
        `CHK(mem[8'h36], 8'hC3)
        `CHK(addr, 16'h1237)
        $display("write test done");
    endtask
    task automatic t_rand_read();
        host_u.start();
        send(8'h90, 1'b1);
        send(8'h12, 1'b1);
        send(8'h35, 1'b1);
        host_u.start();
        send(8'h91, 1'b1);
        rd(1'b0, 8'h5A);
        rd(1'b0, 8'hC3);
        rd(1'b1, 8'hC8);
        host_u.stop();
        wait_idle();
        `CHK(addr, 16'h1238)
        $display("random read test done");
    endtask
    task automatic t_cur_read();
        host_u.start();
        send(8'h91, 1'b1);
        rd(1'b1, 8'hC7);
        host_u.stop();
        wait_idle();
        `CHK(addr, 16'h1239)
        $display("current read test done");
    endtask
    task automatic t_wrong();
        host_u.start();
        send(8'hBA, 1'b0);
        send(8'h00, 1'b0);
        host_u.stop();
        wait_idle();
        `CHK(addr, 16'h1239)
        $display("foreign address test done");
    endtask
    task automatic t_strap();
        do_reset(1'b1);
        host_u.start();
        send(8'hBA, 1'b1);
        send(8'h00, 1'b1);
        send(8'h40, 1'b1);
        send(8'h7E, 1'b1);
        host_u.start();
        send(8'hBB, 1'b1);
        rd(1'b1, 8'hBE);
        host_u.stop();
        wait_idle();
        `CHK(mem[8'h40], 8'h7E)
        host_u.start();
        send(8'h90, 1'b0);
        host_u.stop();
        wait_idle();
        $display("strap test done");
    endtask
    initial begin
        reset = 1'b1;
        pin_sel = 1'b0;
        miscompares = 0;
        comparisons = 0;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hFF;
        do_reset(1'b0);
        t_write();
        t_rand_read();
        t_cur_read();
        t_wrong();
        t_strap();
        finish_test();
    end
endmodule
